// ---- logic/ad_twi_dev.sv ----
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`include "ad_twi_cfg.svh"
module ad_twi_dev #(
  parameter logic [7:0] REVISION  = 8'h11,
  // Arbitrary identification value.
  parameter logic [7:0] DEVICE_ID = 8'h5A
) (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  ad_twi_if.device         link,
  input  wire logic [7:0]  fault_code_i,
  input  wire logic [7:0]  sync_status_i,
  input  wire logic [15:0] anc_count_i,
  input  wire logic [15:0] frame_header_i,
  output logic      [7:0]  clock_synth_control_o,
  output logic      [7:0]  clock_synth_multiplier_o,
  output logic      [7:0]  clock_synth_input_divider_o,
  output logic      [7:0]  request_line_polarity_o,
  output logic      [7:0]  input_clock_edge_select_o,
  output logic      [7:0]  playback_run_o,
  output logic      [7:0]  output_silence_o,
  output logic      [7:0]  command_interrupt_o,
  output logic      [7:0]  request_line_enable_o,
  output logic             soft_reset_o
);
  logic [2:0]                scl_sy;
  logic [2:0]                sda_sy;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_det;
  logic                      stop_det;
  ad_twi_pkg::ad_dev_state_t state;
  ad_twi_pkg::ad_byte_kind_t kind;
  logic                      rd_dir;
  logic [3:0]                bitcnt;
  logic [7:0]                shreg;
  logic [7:0]                ptr;
  logic                      sda_oe;
  logic                      macked;
  logic                      wr_stb;
  logic [7:0]                wr_addr;
  logic [7:0]                wr_data;
  logic [7:0]                rd_byte;

  // The device only ever pulls SDA low; SCL is never an output here.
  assign link.s_sda_o  = 1'b0;
  assign link.s_sda_oe = sda_oe;

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
    end
    else
    begin
      scl_sy <= {scl_sy[1:0], link.scl};
      sda_sy <= {sda_sy[1:0], link.sda};
    end
  end

  assign scl_rise  = scl_sy[1] && !scl_sy[2];
  assign scl_fall  = !scl_sy[1] && scl_sy[2];
  // SDA edges only count as conditions while SCL is high on both samples.
  assign start_det = scl_sy[1] && scl_sy[2] && sda_sy[2] && !sda_sy[1];
  assign stop_det  = scl_sy[1] && scl_sy[2] && !sda_sy[2] && sda_sy[1];

  always_comb
  begin
    rd_byte = 8'h00;
    if (ptr == `AD_REG_REVISION)
      rd_byte = REVISION;
    else if (ptr == `AD_REG_IDENT)
      rd_byte = DEVICE_ID;
    else if (ptr == `AD_REG_SYN_CTL)
      rd_byte = clock_synth_control_o;
    else if (ptr == `AD_REG_SYN_MUL)
      rd_byte = clock_synth_multiplier_o;
    else if (ptr == `AD_REG_SYN_DIV)
      rd_byte = clock_synth_input_divider_o;
    else if (ptr == `AD_REG_REQUEST_LINE_POLARITY)
      rd_byte = request_line_polarity_o;
    else if (ptr == `AD_REG_EDGE_SEL)
      rd_byte = input_clock_edge_select_o;
    else if (ptr == `AD_REG_FAULT)
      rd_byte = fault_code_i;
    else if (ptr == `AD_REG_PLAYBACK_RUN)
      rd_byte = playback_run_o;
    else if (ptr == `AD_REG_SILENCE)
      rd_byte = output_silence_o;
    else if (ptr == `AD_REG_CMD_IRQ)
      rd_byte = command_interrupt_o;
    else if (ptr == `AD_REG_REQ_EN)
      rd_byte = request_line_enable_o;
    else if (ptr == `AD_REG_SYNC_STAT)
      rd_byte = sync_status_i;
    else if (ptr == `AD_REG_ANC_LOW)
      rd_byte = anc_count_i[7:0];
    else if (ptr == `AD_REG_ANC_HIGH)
      rd_byte = anc_count_i[15:8];
    else if (ptr == `AD_REG_HEAD_HIGH)
      rd_byte = frame_header_i[15:8];
    else if (ptr == `AD_REG_HEAD_MID)
      rd_byte = frame_header_i[7:0];
  end

  // Protocol engine. SDA is updated a few core cycles after SCL falls,
  // well inside the low phase, so the device never makes a false condition.
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state   <= ad_twi_pkg::AD_D_IDLE;
      kind    <= ad_twi_pkg::AD_K_ADDR;
      rd_dir  <= 1'b0;
      bitcnt  <= 4'h0;
      shreg   <= 8'h00;
      ptr     <= 8'h00;
      sda_oe  <= 1'b0;
      macked  <= 1'b0;
      wr_stb  <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (start_det)
      begin
        state  <= ad_twi_pkg::AD_D_RECV;
        kind   <= ad_twi_pkg::AD_K_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (stop_det)
      begin
        state  <= ad_twi_pkg::AD_D_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        case (state)
          ad_twi_pkg::AD_D_IDLE:
          begin
            sda_oe <= 1'b0;
          end
          ad_twi_pkg::AD_D_RECV:
          begin
            if (scl_rise)
            begin
              shreg  <= {shreg[6:0], sda_sy[1]};
              bitcnt <= bitcnt + 4'h1;
            end
            else if (scl_fall && bitcnt == `AD_BYTE_LAST_BIT)
            begin
              if (kind == ad_twi_pkg::AD_K_ADDR)
              begin
                if (shreg[7:1] == `AD_DEV_ADDR)
                begin
                  rd_dir <= shreg[0];
                  sda_oe <= 1'b1;
                  state  <= ad_twi_pkg::AD_D_ACK;
                end
                else
                begin
                  state <= ad_twi_pkg::AD_D_IDLE;
                end
              end
              else if (kind == ad_twi_pkg::AD_K_SUB)
              begin
                ptr    <= shreg;
                sda_oe <= 1'b1;
                state  <= ad_twi_pkg::AD_D_ACK;
              end
              else
              begin
                wr_stb  <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shreg;
                ptr     <= ptr + 8'h01;
                sda_oe  <= 1'b1;
                state   <= ad_twi_pkg::AD_D_ACK;
              end
            end
          end
          ad_twi_pkg::AD_D_ACK:
          begin
            if (scl_fall)
            begin
              bitcnt <= 4'h0;
              if (rd_dir == `AD_DIR_READ)
              begin
                shreg  <= rd_byte;
                sda_oe <= !rd_byte[7];
                ptr    <= ptr + 8'h01;
                state  <= ad_twi_pkg::AD_D_SEND;
              end
              else
              begin
                sda_oe <= 1'b0;
                if (kind == ad_twi_pkg::AD_K_ADDR)
                  kind <= ad_twi_pkg::AD_K_SUB;
                else
                  kind <= ad_twi_pkg::AD_K_DATA;
                state <= ad_twi_pkg::AD_D_RECV;
              end
            end
          end
          ad_twi_pkg::AD_D_SEND:
          begin
            if (scl_rise)
            begin
              bitcnt <= bitcnt + 4'h1;
            end
            else if (scl_fall)
            begin
              if (bitcnt == `AD_BYTE_LAST_BIT)
              begin
                sda_oe <= 1'b0;
                state  <= ad_twi_pkg::AD_D_MACK;
              end
              else
              begin
                shreg  <= {shreg[6:0], 1'b0};
                sda_oe <= !shreg[6];
              end
            end
          end
          ad_twi_pkg::AD_D_MACK:
          begin
            if (scl_rise)
            begin
              macked <= !sda_sy[1];
            end
            else if (scl_fall)
            begin
              bitcnt <= 4'h0;
              if (macked)
              begin
                shreg  <= rd_byte;
                sda_oe <= !rd_byte[7];
                ptr    <= ptr + 8'h01;
                state  <= ad_twi_pkg::AD_D_SEND;
              end
              else
              begin
                state <= ad_twi_pkg::AD_D_IDLE;
              end
            end
          end
          default:
          begin
            state <= ad_twi_pkg::AD_D_IDLE;
          end
        endcase
      end
    end
  end

  // Writes to read-only or unmapped addresses are simply dropped.
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      clock_synth_control_o       <= `AD_RST_SYN_CTL;
      clock_synth_multiplier_o    <= `AD_RST_SYN_MUL;
      clock_synth_input_divider_o <= `AD_RST_SYN_DIV;
      request_line_polarity_o     <= `AD_RST_REQUEST_LINE_POLARITY;
      input_clock_edge_select_o   <= `AD_RST_EDGE_SEL;
      playback_run_o              <= `AD_RST_PLAYBACK_RUN;
      output_silence_o            <= `AD_RST_ZERO;
      command_interrupt_o         <= `AD_RST_ZERO;
      request_line_enable_o       <= `AD_RST_ZERO;
      soft_reset_o                <= 1'b0;
    end
    else
    begin
      soft_reset_o <= wr_stb && (wr_addr == `AD_REG_SOFT_RST);
      if (wr_stb)
      begin
        if (wr_addr == `AD_REG_SYN_CTL)
          clock_synth_control_o <= wr_data;
        else if (wr_addr == `AD_REG_SYN_MUL)
          clock_synth_multiplier_o <= wr_data;
        else if (wr_addr == `AD_REG_SYN_DIV)
          clock_synth_input_divider_o <= wr_data;
        else if (wr_addr == `AD_REG_REQUEST_LINE_POLARITY)
          request_line_polarity_o <= wr_data;
        else if (wr_addr == `AD_REG_EDGE_SEL)
          input_clock_edge_select_o <= wr_data;
        else if (wr_addr == `AD_REG_PLAYBACK_RUN)
          playback_run_o <= wr_data;
        else if (wr_addr == `AD_REG_SILENCE)
          output_silence_o <= wr_data;
        else if (wr_addr == `AD_REG_CMD_IRQ)
          command_interrupt_o <= wr_data;
        else if (wr_addr == `AD_REG_REQ_EN)
          request_line_enable_o <= wr_data;
      end
    end
  end
endmodule

// ---- logic/ad_twi_cfg.svh ----
`ifndef AD_TWI_CFG_SVH
`define AD_TWI_CFG_SVH
// Behaviour
// - Device is slave only, never drives clock
// - Master starts transfers and generates clock
// - SDA changes only while SCL is low
// - Start is SDA falling with SCL high
// - Stop is SDA rising, ends communication
// - Receiver pulls SDA low on ninth pulse
// - Device samples SDA on SCL rising edge
// - Address byte MSB first, address 1000011
// - Address LSB: one reads, zero writes
// - Device acknowledges matching address on ninth bit
// - Write: second byte loads address counter
// - Single write: one data byte, then stop
// - Multibyte write acknowledged until stop
// - Address counter increments after every byte
// - Current read: data, master nacks, stop
// - Master ack requests next consecutive byte
// - Sequential read starts current or random
// - Registers are whole eight bit values
// - Register without reset value is undefined
// - Master avoids reserved and read-only writes

`define AD_DEV_ADDR        7'h43
`define AD_BYTE_LAST_BIT   4'h8
`define AD_DIR_READ        1'b1

`define AD_REG_REVISION    8'h00
`define AD_REG_IDENT       8'h01
`define AD_REG_SYN_CTL     8'h05
`define AD_REG_SYN_MUL     8'h06
`define AD_REG_SYN_DIV     8'h07
`define AD_REG_REQUEST_LINE_POLARITY     8'h0C
`define AD_REG_EDGE_SEL    8'h0D
`define AD_REG_FAULT       8'h0F
`define AD_REG_SOFT_RST    8'h10
`define AD_REG_PLAYBACK_RUN        8'h13
`define AD_REG_SILENCE     8'h14
`define AD_REG_CMD_IRQ     8'h16
`define AD_REG_REQ_EN      8'h18
`define AD_REG_SYNC_STAT   8'h40
`define AD_REG_ANC_LOW     8'h41
`define AD_REG_ANC_HIGH    8'h42
`define AD_REG_HEAD_HIGH   8'h43
`define AD_REG_HEAD_MID    8'h44

`define AD_RST_SYN_CTL     8'hA1
`define AD_RST_SYN_MUL     8'h0C
`define AD_RST_SYN_DIV     8'h00
`define AD_RST_REQUEST_LINE_POLARITY     8'h01
`define AD_RST_EDGE_SEL    8'h04
`define AD_RST_PLAYBACK_RUN        8'h01
`define AD_RST_ZERO        8'h00

`define AD_APB_CTRL        8'h00
`define AD_APB_SUB         8'h04
`define AD_APB_WDATA       8'h08
`define AD_APB_RDATA       8'h0C
`define AD_APB_STATUS      8'h10
`define AD_CTRL_GO         0
`define AD_CTRL_READ       1
`define AD_CTRL_RANDOM     2
`define AD_CTRL_CNT_LO     4
`define AD_STAT_BUSY       0
`define AD_STAT_NACK       1

`define AD_CLK_MHZ         100
`define AD_SCL_QUARTER_NS  625
`define AD_SCL_QUARTER_CYC ((`AD_SCL_QUARTER_NS * `AD_CLK_MHZ + 999) / 1000)
`endif

// ---- logic/ad_twi_pkg.sv ----
package ad_twi_pkg;
  typedef enum logic [2:0] {
    AD_D_IDLE = 3'b000,
    AD_D_RECV = 3'b001,
    AD_D_ACK  = 3'b010,
    AD_D_SEND = 3'b011,
    AD_D_MACK = 3'b100
  } ad_dev_state_t;
  typedef enum logic [1:0] {
    AD_K_ADDR = 2'b00,
    AD_K_SUB  = 2'b01,
    AD_K_DATA = 2'b10
  } ad_byte_kind_t;
  typedef enum logic [2:0] {
    AD_H_IDLE  = 3'b000,
    AD_H_START = 3'b001,
    AD_H_TX    = 3'b010,
    AD_H_RX    = 3'b011,
    AD_H_STOP  = 3'b100
  } ad_host_state_t;
endpackage

// ---- logic/ad_twi_if.sv ----
`timescale 1ns/1ns
interface ad_twi_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic sda;
  // Open drain with pull-up: any enabled driver holding zero wins.
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport device (input scl, output s_sda_o, output s_sda_oe, input sda);
endinterface

// ---- logic/ad_twi_host.sv ----
`timescale 1ns/1ns
`include "ad_twi_cfg.svh"
module ad_twi_host (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  ad_twi_if.master         link
);
  localparam int QCYC = `AD_SCL_QUARTER_CYC;

  logic                       go;
  logic                       cmd_read;
  logic                       cmd_random;
  logic [1:0]                 cmd_cnt;
  logic [7:0]                 sub;
  logic [31:0]                wdata;
  logic [31:0]                rdata;
  logic                       busy;
  logic                       nack;
  logic [1:0]                 sda_sy;
  logic [7:0]                 qdiv;
  logic                       tick;
  logic [1:0]                 phase;
  ad_twi_pkg::ad_host_state_t state;
  ad_twi_pkg::ad_byte_kind_t  kind;
  logic                       rd_phase;
  logic [3:0]                 bitcnt;
  logic [7:0]                 shreg;
  logic [1:0]                 idx;
  logic                       acked;
  logic                       scl;
  logic                       sda_oe;
  logic                       addr_dir;

  assign link.scl      = scl;
  assign link.m_sda_o  = 1'b0;
  assign link.m_sda_oe = sda_oe;
  assign pready_o      = 1'b1;
  assign addr_dir      = cmd_read && (!cmd_random || rd_phase);

  // Read data and error are prepared in the setup cycle for a zero-wait access.
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prdata_o   <= 32'h0000_0000;
      pslverr_o  <= 1'b0;
      go         <= 1'b0;
      cmd_read   <= 1'b0;
      cmd_random <= 1'b0;
      cmd_cnt    <= 2'h0;
      sub        <= 8'h00;
      wdata      <= 32'h0000_0000;
    end
    else
    begin
      go <= 1'b0;
      if (psel_i && !penable_i)
      begin
        pslverr_o <= 1'b0;
        prdata_o  <= 32'h0000_0000;
        if (paddr_i == `AD_APB_CTRL)
          prdata_o <= {26'h000_0000, cmd_cnt, 1'b0, cmd_random, cmd_read, 1'b0};
        else if (paddr_i == `AD_APB_SUB)
          prdata_o <= {24'h00_0000, sub};
        else if (paddr_i == `AD_APB_WDATA)
          prdata_o <= wdata;
        else if (paddr_i == `AD_APB_RDATA)
          prdata_o <= rdata;
        else if (paddr_i == `AD_APB_STATUS)
          prdata_o <= {30'h0000_0000, nack, busy};
        else
          pslverr_o <= 1'b1;
      end
      if (psel_i && penable_i && pwrite_i && !busy)
      begin
        if (paddr_i == `AD_APB_CTRL)
        begin
          go         <= pwdata_i[`AD_CTRL_GO];
          cmd_read   <= pwdata_i[`AD_CTRL_READ];
          cmd_random <= pwdata_i[`AD_CTRL_RANDOM];
          cmd_cnt    <= pwdata_i[`AD_CTRL_CNT_LO +: 2];
        end
        else if (paddr_i == `AD_APB_SUB)
          sub <= pwdata_i[7:0];
        else if (paddr_i == `AD_APB_WDATA)
          wdata <= pwdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sda_sy <= 2'h3;
      qdiv   <= 8'h00;
    end
    else
    begin
      sda_sy <= {sda_sy[0], link.sda};
      if (state == ad_twi_pkg::AD_H_IDLE || tick)
        qdiv <= 8'h00;
      else
        qdiv <= qdiv + 8'h01;
    end
  end

  assign tick = (qdiv == 8'(QCYC - 1));

  // Each bit takes four quarters: drive or release SDA, raise SCL, sample, drop SCL.
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state    <= ad_twi_pkg::AD_H_IDLE;
      kind     <= ad_twi_pkg::AD_K_ADDR;
      phase    <= 2'h0;
      rd_phase <= 1'b0;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      idx      <= 2'h0;
      acked    <= 1'b0;
      scl      <= 1'b1;
      sda_oe   <= 1'b0;
      busy     <= 1'b0;
      nack     <= 1'b0;
      rdata    <= 32'h0000_0000;
    end
    else if (state == ad_twi_pkg::AD_H_IDLE)
    begin
      scl    <= 1'b1;
      sda_oe <= 1'b0;
      phase  <= 2'h0;
      if (go)
      begin
        busy     <= 1'b1;
        nack     <= 1'b0;
        rd_phase <= 1'b0;
        idx      <= 2'h0;
        state    <= ad_twi_pkg::AD_H_START;
      end
    end
    else if (tick)
    begin
      phase <= phase + 2'h1;
      case (state)
        ad_twi_pkg::AD_H_START:
        begin
          if (phase == 2'h0)
            sda_oe <= 1'b0;
          else if (phase == 2'h1)
            scl <= 1'b1;
          else if (phase == 2'h2)
            sda_oe <= 1'b1;
          else
          begin
            scl    <= 1'b0;
            kind   <= ad_twi_pkg::AD_K_ADDR;
            shreg  <= {`AD_DEV_ADDR, addr_dir};
            bitcnt <= 4'h0;
            state  <= ad_twi_pkg::AD_H_TX;
          end
        end
        ad_twi_pkg::AD_H_TX,
        ad_twi_pkg::AD_H_RX:
        begin
          if (phase == 2'h0)
          begin
            if (state == ad_twi_pkg::AD_H_TX)
              sda_oe <= (bitcnt != `AD_BYTE_LAST_BIT) && !shreg[7];
            else
              sda_oe <= (bitcnt == `AD_BYTE_LAST_BIT) && (idx != cmd_cnt);
          end
          else if (phase == 2'h1)
            scl <= 1'b1;
          else if (phase == 2'h2)
          begin
            if (bitcnt == `AD_BYTE_LAST_BIT)
              acked <= !sda_sy[1];
            else if (state == ad_twi_pkg::AD_H_RX)
              shreg <= {shreg[6:0], sda_sy[1]};
          end
          else
          begin
            scl    <= 1'b0;
            bitcnt <= bitcnt + 4'h1;
            if (state == ad_twi_pkg::AD_H_TX && bitcnt != `AD_BYTE_LAST_BIT)
              shreg <= {shreg[6:0], 1'b0};
            if (bitcnt == `AD_BYTE_LAST_BIT)
            begin
              bitcnt <= 4'h0;
              if (state == ad_twi_pkg::AD_H_RX)
              begin
                rdata[{idx, 3'h0} +: 8] <= shreg;
                idx <= idx + 2'h1;
                if (idx == cmd_cnt)
                  state <= ad_twi_pkg::AD_H_STOP;
              end
              else if (!acked)
              begin
                nack  <= 1'b1;
                state <= ad_twi_pkg::AD_H_STOP;
              end
              else if (kind == ad_twi_pkg::AD_K_ADDR)
              begin
                if (addr_dir)
                  state <= ad_twi_pkg::AD_H_RX;
                else
                begin
                  kind  <= ad_twi_pkg::AD_K_SUB;
                  shreg <= sub;
                end
              end
              else if (kind == ad_twi_pkg::AD_K_SUB && cmd_read)
              begin
                rd_phase <= 1'b1;
                state    <= ad_twi_pkg::AD_H_START;
              end
              else if (kind == ad_twi_pkg::AD_K_DATA && idx == cmd_cnt)
                state <= ad_twi_pkg::AD_H_STOP;
              else
              begin
                if (kind == ad_twi_pkg::AD_K_DATA)
                  idx <= idx + 2'h1;
                kind  <= ad_twi_pkg::AD_K_DATA;
                shreg <= (kind == ad_twi_pkg::AD_K_DATA) ?
                         wdata[{idx + 2'h1, 3'h0} +: 8] : wdata[7:0];
              end
            end
          end
        end
        ad_twi_pkg::AD_H_STOP:
        begin
          if (phase == 2'h0)
            sda_oe <= 1'b1;
          else if (phase == 2'h1)
            scl <= 1'b1;
          else if (phase == 2'h2)
            sda_oe <= 1'b0;
          else
          begin
            busy  <= 1'b0;
            state <= ad_twi_pkg::AD_H_IDLE;
          end
        end
        default:
        begin
          state <= ad_twi_pkg::AD_H_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- verif/ad_twi_props.sv ----
`timescale 1ns/1ns
`include "ad_twi_cfg.svh"
module ad_twi_props (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] nb;
  logic [7:0] sh;
  wire        rise  = scl && !scl_q;
  wire        start = scl && scl_q && sda_q && !sda;
  wire        stop  = scl && scl_q && !sda_q && sda;
  // The count saturates, so only the select byte after a start is judged.
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      nb    <= 4'h0;
      sh    <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      nb    <= start ? 4'h0 : (rise && nb != 4'hF) ? nb + 4'h1 : nb;
      sh    <= rise ? {sh[6:0], sda} : sh;
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  property p_ack; rise && nb == 4'h8 |-> !sda == (sh[7:1] == `AD_DEV_ADDR); endproperty
  a_ack: assert property (p_ack) else $error("select ack wrong");
  property p_rel; rise && nb == 4'h8 |-> !m_sda_oe; endproperty
  a_rel: assert property (p_rel) else $error("master held ack bit");
  property p_hold; rise |-> sda == sda_q; endproperty
  a_hold: assert property (p_hold) else $error("sda moved at scl rise");
  property p_chg; $changed(s_sda_oe) |-> !scl; endproperty
  a_chg: assert property (p_chg) else $error("device moved sda, scl high");
  property p_od; s_sda_oe |-> !s_sda_o; endproperty
  a_od: assert property (p_od) else $error("device drove high");
  property p_low; $fell(scl) |=> !scl [*8]; endproperty
  a_low: assert property (p_low) else $error("scl low phase short");
  property p_sta; start |=> !s_sda_oe [*8]; endproperty
  a_sta: assert property (p_sta) else $error("device drove after start");
  property p_sto; stop |=> !s_sda_oe [*8]; endproperty
  a_sto: assert property (p_sto) else $error("device drove after stop");
  c_sta: cover property (start);
  c_ack: cover property (rise && nb == 4'h8 && !sda);
  c_sto: cover property (stop);
endmodule

// ---- verif/ad_twi_tb.sv ----
`timescale 1ns/1ns
`include "ad_twi_cfg.svh"
module ad_twi_tb;
  // Arbitrary identification values.
  localparam logic [7:0] REV = 8'h27;
  localparam logic [7:0] DID = 8'h3C;
  logic        core_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r, wd;
  logic        pready, pslverr, srst;
  logic [7:0]  fault = 8'h00, sync = 8'h00, ctl, mul, div, pol, edg, playback_run, sil, cmd, ren;
  logic [15:0] anc = 16'h0000, head = 16'h0000;
  int          miscompares = 0, n_compared = 0, seed = 57, n_srst = 0;
  ad_twi_if link ();
  ad_twi_host i_ad_twi_host (.core_clk_i, .arst_n_i, .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .link(link));
  ad_twi_dev #(.REVISION(REV), .DEVICE_ID(DID)) i_ad_twi_dev (.core_clk_i, .arst_n_i,
    .link(link), .fault_code_i(fault), .sync_status_i(sync), .anc_count_i(anc),
    .frame_header_i(head), .clock_synth_control_o(ctl), .clock_synth_multiplier_o(mul),
    .clock_synth_input_divider_o(div), .request_line_polarity_o(pol),
    .input_clock_edge_select_o(edg), .playback_run_o(playback_run), .output_silence_o(sil),
    .command_interrupt_o(cmd), .request_line_enable_o(ren), .soft_reset_o(srst));
  ad_twi_props i_ad_twi_props (.core_clk_i, .arst_n_i, .scl(link.scl), .sda(link.sda),
    .m_sda_oe(link.m_sda_oe), .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe));
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (srst === 1'b1) n_srst++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Two bytes read in sequence land low byte first in the read word.
  function automatic logic [15:0] exp_pair(input logic [7:0] first, input logic [7:0] second);
    exp_pair = {second, first};
  endfunction
  task automatic finish_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    pen <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  // Control byte: go, read, random, then byte count less one in bits 5:4.
  task automatic xfer(input logic [7:0] c, input logic [7:0] s);
    apb(1'b1, `AD_APB_SUB, {24'h00_0000, s});
    apb(1'b1, `AD_APB_WDATA, wd);
    apb(1'b1, `AD_APB_CTRL, {24'h00_0000, c});
    do apb(1'b0, `AD_APB_STATUS, 32'h0000_0000); while (r[`AD_STAT_BUSY] !== 1'b0);
    chk(32'(r[`AD_STAT_NACK]), 32'h0000_0000);
    apb(1'b0, `AD_APB_RDATA, 32'h0000_0000);
  endtask
  initial
  begin
    wd = 32'h0000_0000;
    repeat (4) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    {fault, sync, anc} <= $random(seed);
    wd = $random(seed);
    head <= wd[31:16];
    chk({ctl, mul, div, pol}, 32'hA10C_0001);
    chk({edg, playback_run, sil, cmd}, 32'h0401_0000);
    // Every transfer stays on documented addresses and never writes a read-only one.
    xfer(8'h27, 8'h05);
    chk({8'h00, r[23:0]}, 32'h0000_0CA1);
    wd = $random(seed);
    xfer(8'h21, 8'h05);
    chk({8'h00, div, mul, ctl}, {8'h00, wd[23:0]});
    xfer(8'h01, 8'h10);
    chk(n_srst, 1);
    chk({playback_run, sil, cmd, ren}, 32'h0100_0000);
    xfer(8'h01, 8'h0C);
    chk(32'(pol), 32'(wd[7:0]));
    xfer(8'h03, 8'h00);
    chk(32'(r[7:0]), 32'h0000_0004);
    xfer(8'h07, 8'h0F);
    chk(32'(r[7:0]), 32'(fault));
    xfer(8'h27, 8'h40);
    chk({8'h00, r[23:0]}, {8'h00, anc, sync});
    xfer(8'h13, 8'h00);
    chk(32'(r[15:0]), 32'(exp_pair(head[15:8], head[7:0])));
    xfer(8'h17, 8'h00);
    chk(32'(r[15:0]), {16'h0000, DID, REV});
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0, pslverr}, 32'h0000_0001);
    finish_test;
  end
  // The scripted traffic needs about 0.9 ms; a small margin keeps a hang short.
  initial
  begin
    #1_100_000;
    miscompares++;
    finish_test;
  end
endmodule
